// ### core/bus_cycle_termination.sv
// bus cycle sequencer deciding normal, halt, bus fault or illegal-release endings and retries
// How it works
// - sample at even state N and N+2
// - acknowledge alone ends cycle normally
// - stop with acknowledge: finish, then halt
// - fault without stop aborts into fault trap
// - late fault traps only in late variant
// - fault with stop terminates, retries later
// - late fault plus stop retries, late variant
// - ordered release after retry reruns cycle
// - wrong release order traps vector zero
// - late released acknowledge lengthens next cycle
// - fault still held faults next cycle
// - retry floats bus, repeats identical cycle
// - fault trap uses exception entry two
// - read-modify-write never retried, fault with stop faults
`timescale 1ns/100ps
`default_nettype none
module bus_cycle_termination
  import bct_pkg::*;
#(
  parameter bit LATE_ERR = 1'b0,
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int DATA_W = DATA_W_DEF,
  parameter int FC_W = FC_W_DEF
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // cycle request from the core
  input wire logic cyc_req_i,
  input wire logic cyc_rmw_i,
  input wire logic cyc_write_i,
  input wire logic [FC_W-1:0] cyc_fc_i,
  input wire logic [ADDR_W-1:0] cyc_addr_i,
  input wire logic [DATA_W-1:0] cyc_wdata_i,
  output logic cyc_ready_o,
  // termination pins, active low
  input wire logic transfer_ack_n_i,
  input wire logic bus_fault_n_i,
  input wire logic stop_req_n_i,
  // bus drive
  output logic addr_strobe_n_o,
  output logic bus_oe_o,
  output logic write_o,
  output logic [FC_W-1:0] fc_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o,
  // outcome towards the core
  output logic done_o,
  output var bct_pkg::term_e term_o,
  output logic trap_o,
  output logic [VEC_W-1:0] trap_vec_o,
  output logic halted_o,
  output logic retrying_o
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WAIT,
    ST_LATE,
    ST_END,
    ST_HALT,
    ST_FLOAT_FAULT,
    ST_FLOAT_RETRY
  } state_e;

  state_e state_r;
  state_e state_nxt;
  term_e end_kind_r;
  term_e end_kind_nxt;
  logic rmw_r;
  logic ack_armed_r;
  logic fault_gone_r;
  logic finish;
  term_e finish_kind;
  logic ack;
  logic fault;
  logic stop;

  term_sync_if pins ();

  // pins arrive from outside the clock domain; input changes on rising edges
  term_pin_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .transfer_ack_n_i(transfer_ack_n_i),
    .bus_fault_n_i(bus_fault_n_i),
    .stop_req_n_i(stop_req_n_i),
    .sync_o(pins)
  );

  // active-high views of the synchronised pins
  assign fault = ~pins.fault_n;
  assign stop = ~pins.stop_n;
  assign ack = ~pins.ack_n & ack_armed_r; // stale acknowledge waits out

  // acknowledge counts only after it was once seen negated
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ack_armed_r <= 1'b0;
    else if (state_r == ST_END)
      ack_armed_r <= 1'b0;
    else if (pins.ack_n)
      ack_armed_r <= 1'b1; // slow release stretches the next wait
  end

  // next-state decision, one sample per clock, each clock an even state
  always_comb
  begin
    state_nxt = state_r;
    end_kind_nxt = end_kind_r;
    finish = 1'b0;
    finish_kind = TERM_NONE;
    unique case (state_r)
      ST_IDLE:
      begin
        if (stop)
          state_nxt = ST_HALT; // stop between cycles holds the bus idle
        else if (cyc_req_i)
          state_nxt = ST_ADDR;
      end
      ST_ADDR:
        state_nxt = ST_WAIT;
      ST_WAIT:
      begin
        // sampling at state N
        if (fault && stop && !rmw_r)
          state_nxt = ST_FLOAT_RETRY; // fault plus stop asks for a retry
        else if (fault)
          state_nxt = ST_FLOAT_FAULT; // abort whatever the acknowledge does
        else if (ack)
        begin
          end_kind_nxt = stop ? TERM_HALT : TERM_NORMAL;
          state_nxt = LATE_ERR ? ST_LATE : ST_END; // late look only if enabled
        end
      end
      ST_LATE:
      begin
        // second look at state N+2
        if (fault && stop && !rmw_r)
          state_nxt = ST_FLOAT_RETRY; // late retry
        else if (fault)
          state_nxt = ST_FLOAT_FAULT; // late bus fault
        else
        begin
          if (stop)
            end_kind_nxt = TERM_HALT;
          state_nxt = ST_END;
        end
      end
      ST_END:
      begin
        finish = 1'b1;
        finish_kind = end_kind_r;
        state_nxt = (end_kind_r == TERM_HALT) ? ST_HALT : ST_IDLE;
      end
      ST_HALT:
      begin
        if (!stop)
          state_nxt = ST_IDLE; // resume when stop is released
      end
      ST_FLOAT_FAULT:
      begin
        // trap only once the fault line is released
        if (!fault)
        begin
          finish = 1'b1;
          finish_kind = TERM_FAULT;
          state_nxt = ST_IDLE;
        end
      end
      ST_FLOAT_RETRY:
      begin
        if (!stop)
        begin
          if (fault_gone_r)
            state_nxt = ST_ADDR; // rerun with the held cycle
          else
          begin
            finish = 1'b1;
            finish_kind = TERM_ILLEGAL; // stop dropped first or together
            state_nxt = ST_IDLE;
          end
        end
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      end_kind_r <= TERM_NONE;
    end
    else
    begin
      state_r <= state_nxt;
      end_kind_r <= end_kind_nxt;
    end
  end

  // fault released in an earlier clock than stop during a retry wait
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      fault_gone_r <= 1'b0;
    else if (state_r != ST_FLOAT_RETRY)
      fault_gone_r <= 1'b0;
    else if (!fault)
      fault_gone_r <= 1'b1; // stop must outlast fault by a clock
  end

  // cycle attributes captured once, kept for any rerun
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rmw_r <= 1'b0;
      write_o <= 1'b0;
      fc_o <= '0;
      addr_o <= '0;
      wdata_o <= '0;
    end
    else if (state_r == ST_IDLE && state_nxt == ST_ADDR)
    begin
      rmw_r <= cyc_rmw_i;
      write_o <= cyc_write_i;
      fc_o <= cyc_fc_i;
      addr_o <= cyc_addr_i;
      wdata_o <= cyc_wdata_i; // identical code, address and data on rerun
    end
  end

  // strobe and bus drive follow the next state
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      addr_strobe_n_o <= 1'b1;
      bus_oe_o <= 1'b0;
    end
    else
    begin
      addr_strobe_n_o <= !(state_nxt == ST_ADDR || state_nxt == ST_WAIT
                           || state_nxt == ST_LATE);
      // address and data float while faulted, retrying or halted
      bus_oe_o <= (state_nxt == ST_ADDR || state_nxt == ST_WAIT
                   || state_nxt == ST_LATE || state_nxt == ST_END);
    end
  end

  // status levels towards the core
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cyc_ready_o <= 1'b0;
      halted_o <= 1'b0;
      retrying_o <= 1'b0;
    end
    else
    begin
      cyc_ready_o <= (state_nxt == ST_IDLE);
      halted_o <= (state_nxt == ST_HALT);
      retrying_o <= (state_nxt == ST_FLOAT_RETRY);
    end
  end

  // one-cycle completion and trap pulses, last outcome held
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      done_o <= 1'b0;
      trap_o <= 1'b0;
      trap_vec_o <= VEC_ILLEGAL;
      term_o <= TERM_NONE;
    end
    else
    begin
      done_o <= finish;
      trap_o <= finish && (finish_kind == TERM_FAULT || finish_kind == TERM_ILLEGAL);
      if (finish)
      begin
        term_o <= finish_kind;
        if (finish_kind == TERM_FAULT)
          trap_vec_o <= VEC_BUS_FAULT; // fault handler entry
        else if (finish_kind == TERM_ILLEGAL)
          trap_vec_o <= VEC_ILLEGAL;
      end
    end
  end

endmodule
`default_nettype wire

// ### core/bct_pkg.sv
// shared constants and types for the bus cycle termination block
package bct_pkg;

  // default widths of the carried bus cycle
  localparam int ADDR_W_DEF = 24;
  localparam int DATA_W_DEF = 16;
  localparam int FC_W_DEF = 3;

  // exception vector numbers reported with a trap
  localparam int VEC_W = 8;
  localparam logic [VEC_W-1:0] VEC_BUS_FAULT = 8'h02;
  localparam logic [VEC_W-1:0] VEC_ILLEGAL = 8'h00;

  // synchroniser depth for the three pins
  localparam int SYNC_STAGES = 2;
  localparam int TERM_PINS = 3;

  // bit positions of the pins inside the synchroniser vector
  localparam int PIN_ACK = 0;
  localparam int PIN_FAULT = 1;
  localparam int PIN_STOP = 2;

  // reset value of the synchronised pins: all negated
  localparam logic [TERM_PINS-1:0] PINS_RST = 3'h7;

  // how a bus cycle finished
  typedef enum logic [2:0] {
    TERM_NONE,
    TERM_NORMAL,
    TERM_HALT,
    TERM_FAULT,
    TERM_RETRY,
    TERM_ILLEGAL
  } term_e;

endpackage

// ### core/term_sync_if.sv
// synchronised termination pins passed from the synchroniser to the sequencer
`timescale 1ns/100ps
`default_nettype none
interface term_sync_if;
  logic ack_n;
  logic fault_n;
  logic stop_n;

  // synchroniser drives, sequencer reads
  modport src (output ack_n, output fault_n, output stop_n);
  modport dst (input ack_n, input fault_n, input stop_n);
endinterface
`default_nettype wire

// ### core/term_pin_sync.sv
// two-stage synchroniser for the active-low termination pins
`timescale 1ns/100ps
`default_nettype none
module term_pin_sync
  import bct_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // raw pins
  input wire logic transfer_ack_n_i,
  input wire logic bus_fault_n_i,
  input wire logic stop_req_n_i,
  // synchronised levels
  term_sync_if.src sync_o
);

  logic [TERM_PINS-1:0] pins_raw;
  logic [TERM_PINS-1:0] meta_r;
  logic [TERM_PINS-1:0] stable_r;

  assign pins_raw[PIN_ACK] = transfer_ack_n_i;
  assign pins_raw[PIN_FAULT] = bus_fault_n_i;
  assign pins_raw[PIN_STOP] = stop_req_n_i;

  // one two-flop chain per pin; first stage feeds only the second
  for (genvar g = 0; g < TERM_PINS; g++)
  begin : g_sync
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        meta_r[g] <= PINS_RST[g];
        stable_r[g] <= PINS_RST[g];
      end
      else
      begin
        meta_r[g] <= pins_raw[g];
        stable_r[g] <= meta_r[g];
      end
    end
  end

  assign sync_o.ack_n = stable_r[PIN_ACK];
  assign sync_o.fault_n = stable_r[PIN_FAULT];
  assign sync_o.stop_n = stable_r[PIN_STOP];

endmodule
`default_nettype wire

// ### verif/bct_checker.sv
// concurrent checks on the termination block ports
`timescale 1ns/100ps
`default_nettype none
module bct_checker
  import bct_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int FC_W = FC_W_DEF
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // watched outputs
  input wire logic cyc_ready_o,
  input wire logic addr_strobe_n_o,
  input wire logic bus_oe_o,
  input wire logic [FC_W-1:0] fc_o,
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic done_o,
  input wire bct_pkg::term_e term_o,
  input wire logic trap_o,
  input wire logic [VEC_W-1:0] trap_vec_o,
  input wire logic halted_o,
  input wire logic retrying_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // finished-cycle outcomes
  sequence s_halt_end;
    done_o && term_o == TERM_HALT;
  endsequence
  sequence s_norm_end;
    done_o && term_o == TERM_NORMAL;
  endsequence
  norm_ready_a: assert property (s_norm_end |-> cyc_ready_o)
    else $error("ready missing after normal end");
  halt_enter_a: assert property (s_halt_end |-> ##[0:1] halted_o)
    else $error("no halt after halt end");
  halt_idle_a: assert property (halted_o |-> addr_strobe_n_o)
    else $error("strobe active while halted");
  fault_vec_a: assert property (done_o && term_o == TERM_FAULT |-> trap_o && trap_vec_o == VEC_BUS_FAULT)
    else $error("fault end without trap two");
  illegal_vec_a: assert property (done_o && term_o == TERM_ILLEGAL |-> trap_o && trap_vec_o == VEC_ILLEGAL)
    else $error("illegal release without trap zero");
  trap_done_a: assert property (trap_o |-> done_o && term_o inside {TERM_FAULT, TERM_ILLEGAL})
    else $error("trap outside fault ending");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  retry_float_a: assert property (retrying_o |-> !bus_oe_o && !done_o)
    else $error("bus driven during retry");
  retry_same_a: assert property (retrying_o |-> $stable(addr_o) && $stable(fc_o))
    else $error("cycle changed during retry");
  no_retry_term_a: assert property (term_o != TERM_RETRY)
    else $error("retry shown as ending");
  rerun_strobe_a: assert property ($fell(retrying_o) |-> !addr_strobe_n_o || (done_o && term_o == TERM_ILLEGAL))
    else $error("retry left without rerun or trap");
endmodule
bind bus_cycle_termination bct_checker #(.ADDR_W(ADDR_W), .FC_W(FC_W)) i_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cyc_ready_o(cyc_ready_o),
  .addr_strobe_n_o(addr_strobe_n_o), .bus_oe_o(bus_oe_o), .fc_o(fc_o), .addr_o(addr_o),
  .done_o(done_o), .term_o(term_o), .trap_o(trap_o), .trap_vec_o(trap_vec_o),
  .halted_o(halted_o), .retrying_o(retrying_o)
);
`default_nettype wire

// ### verif/term_slave.sv
// partner slave answering bus cycles in a chosen manner
`timescale 1ns/100ps
`default_nettype none
module term_slave (
  // clock, reset, strobe and answer mode
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic addr_strobe_n_i,
  input wire logic [1:0] mode_i,
  // fault one clock after acknowledge, stop dropped with fault
  input wire logic late_i,
  input wire logic drop_i,
  // termination pins, pulled up when released
  output logic transfer_ack_n_o,
  output logic bus_fault_n_o,
  output logic stop_req_n_o
);
  logic [3:0] cnt_r;
  // pins only move on the rising edge
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 4'h0;
      transfer_ack_n_o <= 1'b1;
      bus_fault_n_o <= 1'b1;
      stop_req_n_o <= 1'b1;
    end
    else if (!addr_strobe_n_i)
    begin
      cnt_r <= cnt_r + 4'h1;
      // mode 0 ack, 1 ack+stop, 2 fault, 3 fault+stop
      if (cnt_r == 4'h2)
      begin
        transfer_ack_n_o <= mode_i[1] && !late_i;
        bus_fault_n_o <= !mode_i[1] || late_i;
        stop_req_n_o <= !mode_i[0] || late_i;
      end
      // late answer: acknowledge first, fault or retry one clock later
      if (cnt_r == 4'h3 && late_i)
      begin
        bus_fault_n_o <= !mode_i[1];
        stop_req_n_o <= !mode_i[0];
      end
    end
    else
    begin
      // ack and fault go with strobe, stop held well after
      transfer_ack_n_o <= 1'b1;
      bus_fault_n_o <= 1'b1;
      cnt_r <= (stop_req_n_o || cnt_r == 4'hF) ? 4'h0 : cnt_r + 4'h1;
      // drop releases stop together with fault, an illegal order
      if (cnt_r == 4'hF || drop_i)
        stop_req_n_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_bus_cycle_termination.sv
// self-checking bench for the bus cycle termination block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_bus_cycle_termination;
  import bct_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic rmw = 1'b0;
  logic [1:0] mode = 2'h0;
  logic late = 1'b0;
  logic drop = 1'b0;
  logic ack_l, fault_l, stop_l, strobe_l, done_l, trap_l, retrying_l;
  term_e term_l;
  logic [23:0] addr = 24'h0;
  logic ack_n, fault_n, stop_n, strobe_n, oe, wr, ready, done, trap, halted, retrying;
  logic [2:0] fc;
  logic [23:0] addr_q;
  logic [15:0] wdata_q;
  logic [7:0] vec;
  term_e term;
  int n_mismatch = 0;
  int tests_run = 0;
  // device under test and its far side
  bus_cycle_termination i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cyc_req_i(req),
    .cyc_rmw_i(rmw), .cyc_write_i(addr[0]), .cyc_fc_i(addr[2:0]), .cyc_addr_i(addr),
    .cyc_wdata_i(addr[15:0]), .cyc_ready_o(ready), .transfer_ack_n_i(ack_n),
    .bus_fault_n_i(fault_n), .stop_req_n_i(stop_n), .addr_strobe_n_o(strobe_n),
    .bus_oe_o(oe), .write_o(wr), .fc_o(fc), .addr_o(addr_q), .wdata_o(wdata_q),
    .done_o(done), .term_o(term), .trap_o(trap), .trap_vec_o(vec), .halted_o(halted),
    .retrying_o(retrying));
  term_slave i_slave (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_strobe_n_i(strobe_n),
    .mode_i(mode), .late_i(late), .drop_i(drop), .transfer_ack_n_o(ack_n),
    .bus_fault_n_o(fault_n), .stop_req_n_o(stop_n));
  // late variant beside it, same requests, its own far side
  bus_cycle_termination #(.LATE_ERR(1'b1)) i_dut_late (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .cyc_req_i(req), .cyc_rmw_i(rmw), .cyc_write_i(addr[0]),
    .cyc_fc_i(addr[2:0]), .cyc_addr_i(addr), .cyc_wdata_i(addr[15:0]), .cyc_ready_o(),
    .transfer_ack_n_i(ack_l), .bus_fault_n_i(fault_l), .stop_req_n_i(stop_l),
    .addr_strobe_n_o(strobe_l), .bus_oe_o(), .write_o(), .fc_o(), .addr_o(), .wdata_o(),
    .done_o(done_l), .term_o(term_l), .trap_o(trap_l), .trap_vec_o(), .halted_o(),
    .retrying_o(retrying_l));
  term_slave i_slave_late (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_strobe_n_i(strobe_l),
    .mode_i(mode), .late_i(late), .drop_i(drop), .transfer_ack_n_o(ack_l),
    .bus_fault_n_o(fault_l), .stop_req_n_o(stop_l));
  // free-running clock
  initial
  begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // a spent wait bound ends the run
  task automatic limit(input int i, input int lim);
    if (i >= lim)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // one cycle: wait idle, request, follow to done, judge ending
  task automatic do_cyc(input logic [1:0] m, input logic rm, input logic [23:0] a,
                        input term_e t, output logic rt);
    int i;
    rt = 1'b0;
    for (i = 0; i < 100 && ready !== 1'b1; i++)
      @(negedge sys_clk_i);
    limit(i, 100);
    @(posedge sys_clk_i);
    mode <= m;
    rmw <= rm;
    addr <= a;
    req <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(negedge sys_clk_i);
      if (ready === 1'b0)
        break;
    end
    limit(i, 100);
    @(posedge sys_clk_i);
    req <= 1'b0;
    for (i = 0; i < 200; i++)
    begin
      @(negedge sys_clk_i);
      if (retrying === 1'b1)
      begin
        rt = 1'b1;
        mode <= 2'h0;
      end
      if (done === 1'b1)
        break;
    end
    limit(i, 200);
    `CHK("term", t, term)
    `CHK("trap", t == TERM_FAULT || t == TERM_ILLEGAL, trap)
  endtask
  task automatic normal_end();
    logic rt;
    do_cyc(2'h0, 1'b0, 24'hA5_1235, TERM_NORMAL, rt);
    do_cyc(2'h0, 1'b0, 24'h00_0FFE, TERM_NORMAL, rt);
    `CHK("addr", 24'h00_0FFE, addr_q)
    `CHK("write", 1'b0, wr)
  endtask
  task automatic halt_end();
    logic rt;
    do_cyc(2'h1, 1'b0, 24'h12_3456, TERM_HALT, rt);
    @(negedge sys_clk_i);
    `CHK("halted", 1'b1, halted)
  endtask
  task automatic fault_end();
    logic rt;
    do_cyc(2'h2, 1'b0, 24'h7F_0002, TERM_FAULT, rt);
    `CHK("vector", 8'h02, vec)
  endtask
  task automatic retry_end();
    logic rt;
    do_cyc(2'h3, 1'b0, 24'h3C_5A5B, TERM_NORMAL, rt);
    `CHK("retried", 1'b1, rt)
    `CHK("addr", 24'h3C_5A5B, addr_q)
    `CHK("wdata", 16'h5A5B, wdata_q)
    `CHK("fc", 3'h3, fc)
    `CHK("write", 1'b1, wr)
  endtask
  // fault after acknowledge: base ends normally, late variant traps or retries
  task automatic late_end(input logic [1:0] m, input term_e tl);
    int i;
    logic rt;
    logic rl;
    late <= 1'b1;
    do_cyc(m, 1'b0, 24'h55_0AA1, TERM_NORMAL, rt);
    mode <= 2'h0;
    rl = 1'b0;
    for (i = 0; i < 200; i++)
    begin
      if (retrying_l === 1'b1)
        rl = 1'b1;
      if (done_l === 1'b1)
        break;
      @(negedge sys_clk_i);
    end
    limit(i, 200);
    late <= 1'b0;
    `CHK("late term", tl, term_l)
    `CHK("late trap", tl == TERM_FAULT, trap_l)
    `CHK("late retried", m[0], rl)
  endtask
  // stop released together with fault during a retry
  task automatic illegal_release();
    logic rt;
    drop <= 1'b1;
    do_cyc(2'h3, 1'b0, 24'h0F_F0F0, TERM_ILLEGAL, rt);
    drop <= 1'b0;
    `CHK("retried", 1'b1, rt)
    `CHK("vector", 8'h00, vec)
  endtask
  task automatic rmw_fault();
    logic rt;
    do_cyc(2'h3, 1'b1, 24'h00_4444, TERM_FAULT, rt);
    `CHK("retried", 1'b0, rt)
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    normal_end();
    halt_end();
    fault_end();
    retry_end();
    late_end(2'h2, TERM_FAULT);
    late_end(2'h3, TERM_NORMAL);
    illegal_release();
    rmw_fault();
    tally_and_finish();
  end
endmodule
`default_nettype wire
